/* logic/core_subset_pkg.sv */
// Package for the instruction subset executer: encodings, widths, carriers.
// Assumes a 14-bit instruction word and a 7-bit file register address.
package core_subset_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;
  localparam int DATA_W  = 8;
  localparam int STACK_D = 8;
  localparam int SP_W    = 3;

  // Opcode masks and match patterns
  localparam logic [INSTR_W-1:0] MASK_FD    = 14'h3F00;
  localparam logic [INSTR_W-1:0] MASK_STORE = 14'h3F80;
  localparam logic [INSTR_W-1:0] MASK_LIT2  = 14'h3C00;
  localparam logic [INSTR_W-1:0] MASK_LIT1  = 14'h3E00;
  localparam logic [INSTR_W-1:0] MASK_FULL  = 14'h3FFF;
  localparam logic [INSTR_W-1:0] OP_COPY    = 14'h0800;
  localparam logic [INSTR_W-1:0] OP_STORE   = 14'h0080;
  localparam logic [INSTR_W-1:0] OP_LOAD    = 14'h3000;
  localparam logic [INSTR_W-1:0] OP_RETLIT  = 14'h3400;
  localparam logic [INSTR_W-1:0] OP_SUBLIT  = 14'h3C00;
  localparam logic [INSTR_W-1:0] OP_ROTL    = 14'h0D00;
  localparam logic [INSTR_W-1:0] OP_ROTR    = 14'h0C00;
  localparam logic [INSTR_W-1:0] OP_RETIRQ  = 14'h0009;
  localparam logic [INSTR_W-1:0] OP_RETSUB  = 14'h0008;
  localparam logic [INSTR_W-1:0] OP_SLEEP   = 14'h0063;

  // Field positions
  localparam int DEST_BIT = 7;
  localparam int MSB_BIT  = 7;
  localparam int NIB_W    = 4;

  // Configuration word: location, and value of an unprogrammed cell
  localparam logic [PC_W:0]        CONFIG_ADDR  = 14'h2007;
  localparam logic [INSTR_W-1:0]   ALL_ONES     = 14'h3FFF;
  localparam logic [PC_W-1:0]      PC_RESET     = 13'h0000;
  localparam logic [DATA_W-1:0]    BYTE_ZERO    = 8'h00;
  localparam logic [PC_W-1:0]      PC_ONE       = 13'h0001;
  localparam logic [SP_W-1:0]      SP_ONE       = 3'h1;

  typedef struct packed {
    logic timeOut;
    logic powerDown;
    logic zero;
    logic digitCarry;
    logic carry;
  } status_type;

  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } file_write_type;

  localparam status_type STATUS_RESET = '{timeOut: 1'b1, powerDown: 1'b1,
                                          zero: 1'b0, digitCarry: 1'b0, carry: 1'b0};
endpackage

/* logic/core_subset_exec.sv */
// Executes a subset of an 8-bit core's instructions: moves, literal loads,
// returns, rotates through carry, literal subtract, power-down entry.
// Assumes program memory returns the word at pc one cycle later on instr,
// and the file space returns the register at instr[6:0] combinationally.
//
// Notes on behaviour
// - Config word at 2007h reads 0 for programmed bits, 1 for unprogrammed.
// - file_copy moves register to accumulator (d=0) or itself (d=1), one cycle.
// - file_copy sets zero flag from moved value, so d=1 tests a register.
// - acc_store writes accumulator to register in one cycle, flags untouched.
// - literal_load puts the immediate into accumulator, one cycle, no flags.
// - interrupt_return pops stack into pc, sets global_irq_enable, two cycles.
// - literal_return loads immediate into accumulator and pc from stack_top.
// - Subroutine return pops stack into pc, two cycles, no flag change.
// - rotate_left_carry shifts register left through carry to chosen destination.
// - rotate_right_carry shifts right through carry; only carry changes.
// - Power-down clears watchdog_counter and its prescaler.
// - Power-down clears power_down_flag and sets time_out.
// - After power-down the core halts with oscillator stopped.
// - literal_minus_acc: k minus accumulator; carry, digit carry, zero updated.
`timescale 1ns/100ps
module core_subset_exec
  import core_subset_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [INSTR_W-1:0]    instr,
  input  wire logic                  instrValid,
  input  wire logic [DATA_W-1:0]     fileRdData,
  input  wire logic                  stackPush,
  input  wire logic [PC_W-1:0]       pushAddr,
  input  wire logic                  wakePin,
  input  wire logic [PC_W:0]         cfgAddr,
  input  wire logic [INSTR_W-1:0]    cfgProgrammed,
  output logic [PC_W-1:0]            pc,
  output logic [DATA_W-1:0]          acc,
  output status_type                 status,
  output file_write_type             fileWrite,
  output logic                       globalIrqEnable,
  output logic                       watchdogClear,
  output logic                       oscHalt,
  output logic [INSTR_W-1:0]         cfgData
);

  logic [PC_W-1:0]   stackMem [STACK_D];
  logic [SP_W-1:0]   sp;
  logic              flush;
  logic              wakeMeta;
  logic              wakeSync;

  // Decode
  wire               exec      = instrValid && !flush && !oscHalt;
  wire               isCopy    = exec && ((instr & MASK_FD) == OP_COPY);
  wire               isStore   = exec && ((instr & MASK_STORE) == OP_STORE);
  wire               isLoad    = exec && ((instr & MASK_LIT2) == OP_LOAD);
  wire               isRetLit  = exec && ((instr & MASK_LIT2) == OP_RETLIT);
  wire               isSubLit  = exec && ((instr & MASK_LIT1) == OP_SUBLIT);
  wire               isRotL    = exec && ((instr & MASK_FD) == OP_ROTL);
  wire               isRotR    = exec && ((instr & MASK_FD) == OP_ROTR);
  wire               isRetIrq  = exec && ((instr & MASK_FULL) == OP_RETIRQ);
  wire               isRetSub  = exec && ((instr & MASK_FULL) == OP_RETSUB);
  wire               isSleep   = exec && ((instr & MASK_FULL) == OP_SLEEP);
  wire               isReturn  = isRetLit || isRetIrq || isRetSub;
  wire               isRot     = isRotL || isRotR;
  wire               toFile    = instr[DEST_BIT];
  wire [FADDR_W-1:0] fAddr     = instr[FADDR_W-1:0];
  wire [DATA_W-1:0]  lit       = instr[DATA_W-1:0];

  // Datapath results
  wire [DATA_W-1:0]  rotLeft   = {fileRdData[DATA_W-2:0], status.carry};
  wire [DATA_W-1:0]  rotRight  = {status.carry, fileRdData[DATA_W-1:1]};
  wire [DATA_W-1:0]  rotVal    = isRotL ? rotLeft : rotRight;
  wire               rotCarry  = isRotL ? fileRdData[MSB_BIT] : fileRdData[0];
  wire [DATA_W:0]    subWide   = {1'b0, lit} - {1'b0, acc};
  wire [DATA_W-1:0]  subVal    = subWide[DATA_W-1:0];
  wire               subCarry  = !subWide[DATA_W];
  wire               subDigit  = acc[NIB_W-1:0] <= lit[NIB_W-1:0];
  wire [SP_W-1:0]    spTop     = sp - SP_ONE;
  wire [PC_W-1:0]    stackTop  = stackMem[spTop];

  wire [DATA_W-1:0]  next_acc  =
      (isCopy && !toFile) ? fileRdData :
      (isRot && !toFile)  ? rotVal :
      (isLoad || isRetLit) ? lit :
      isSubLit ? subVal :
      acc;
  wire               fileWrSel = (isCopy && toFile) || isStore || (isRot && toFile);
  wire [DATA_W-1:0]  fileWrVal = isStore ? acc : (isRot ? rotVal : fileRdData);
  wire [PC_W-1:0]    next_pc   = isReturn ? stackTop : (oscHalt ? pc : pc + PC_ONE);

  // Wake pin comes from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeMeta <= 1'b0;
      wakeSync <= 1'b0;
    end else begin
      wakeMeta <= wakePin;
      wakeSync <= wakeMeta;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= BYTE_ZERO;
      pc  <= PC_RESET;
    end else begin
      acc <= next_acc;
      pc  <= next_pc;
    end
  end

  // Second return cycle fetches from the new pc; the stale word is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      flush <= 1'b0;
    end else begin
      flush <= isReturn;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fileWrite <= '0;
    end else begin
      fileWrite.en   <= fileWrSel;
      fileWrite.addr <= fAddr;
      fileWrite.data <= fileWrVal;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= STATUS_RESET;
    end else begin
      if (isCopy) begin
        status.zero <= (fileRdData == BYTE_ZERO);
      end
      if (isRot) begin
        status.carry <= rotCarry;
      end
      if (isSubLit) begin
        status.carry      <= subCarry;
        status.digitCarry <= subDigit;
        status.zero       <= (subVal == BYTE_ZERO);
      end
      if (isSleep) begin
        status.powerDown <= 1'b0;
        status.timeOut   <= 1'b1;
      end
    end
  end

  // Pops and pushes share one pointer; a pop wins if both arrive together
  always_ff @(posedge clk) begin
    if (rst) begin
      sp <= '0;
    end else if (isReturn) begin
      sp <= spTop;
    end else if (stackPush) begin
      sp <= sp + SP_ONE;
    end
  end

  for (genvar i = 0; i < STACK_D; i++) begin : gStack
    always_ff @(posedge clk) begin
      if (rst) begin
        stackMem[i] <= PC_RESET;
      end else if (stackPush && !isReturn && (sp == SP_W'(i))) begin
        stackMem[i] <= pushAddr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      globalIrqEnable <= 1'b0;
      watchdogClear   <= 1'b0;
      oscHalt         <= 1'b0;
    end else begin
      if (isRetIrq) begin
        globalIrqEnable <= 1'b1;
      end
      watchdogClear <= isSleep;
      if (isSleep) begin
        oscHalt <= 1'b1;
      end else if (wakeSync) begin
        oscHalt <= 1'b0;
      end
    end
  end

  // Only the config location shows inverted cells; elsewhere reads blank
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgData <= ALL_ONES;
    end else if (cfgAddr == CONFIG_ADDR) begin
      cfgData <= ~cfgProgrammed;
    end else begin
      cfgData <= ALL_ONES;
    end
  end

  a_config_invert: assert property (@(posedge clk) disable iff (rst)
    (cfgAddr == CONFIG_ADDR) |=> (cfgData == ~$past(cfgProgrammed)))
    else $error("config readback not inverted");
  a_copy_to_acc: assert property (@(posedge clk) disable iff (rst)
    (isCopy && !toFile) |=> (acc == $past(fileRdData)) && !fileWrite.en)
    else $error("file_copy to accumulator wrong");
  a_copy_zero_flag: assert property (@(posedge clk) disable iff (rst)
    isCopy |=> (status.zero == ($past(fileRdData) == BYTE_ZERO)))
    else $error("file_copy zero flag wrong");
  a_store_keeps_flags: assert property (@(posedge clk) disable iff (rst)
    isStore |=> fileWrite.en && (fileWrite.data == $past(acc)) && $stable(status))
    else $error("acc_store wrong");
  a_load_acc: assert property (@(posedge clk) disable iff (rst)
    isLoad |=> (acc == $past(lit)) && $stable(status))
    else $error("literal_load wrong");
  a_irq_return: assert property (@(posedge clk) disable iff (rst)
    isRetIrq |=> globalIrqEnable && (pc == $past(stackTop)) && (sp == $past(spTop)))
    else $error("interrupt_return wrong");
  a_lit_return: assert property (@(posedge clk) disable iff (rst)
    isRetLit |=> (acc == $past(lit)) && (pc == $past(stackTop)))
    else $error("literal_return wrong");
  a_sub_return: assert property (@(posedge clk) disable iff (rst)
    isRetSub |=> (pc == $past(stackTop)) && $stable(status))
    else $error("return wrong");
  a_rot_left: assert property (@(posedge clk) disable iff (rst)
    isRotL |=> (status.carry == $past(fileRdData[MSB_BIT])))
    else $error("rotate left carry wrong");
  a_rot_right: assert property (@(posedge clk) disable iff (rst)
    isRotR |=> (status.carry == $past(fileRdData[0])) && $stable(status.zero))
    else $error("rotate right carry wrong");
  a_sleep_watchdog: assert property (@(posedge clk) disable iff (rst)
    isSleep |=> watchdogClear ##1 !watchdogClear)
    else $error("watchdog clear pulse wrong");
  a_sleep_status: assert property (@(posedge clk) disable iff (rst)
    isSleep |=> status.timeOut && !status.powerDown)
    else $error("power-down status wrong");
  a_sleep_halt: assert property (@(posedge clk) disable iff (rst)
    (isSleep && !wakeSync) |=> oscHalt ##1 $stable(pc))
    else $error("core not halted");
  a_sub_flags: assert property (@(posedge clk) disable iff (rst)
    isSubLit |=> (status.carry == ($past(acc) <= $past(lit)))
                 && (acc == $past(lit) - $past(acc)))
    else $error("literal_minus_acc wrong");
  a_return_flush: assert property (@(posedge clk) disable iff (rst)
    isReturn |=> flush && !exec ##1 !flush)
    else $error("return did not discard prefetch");

endmodule

/* bench/core_subset_exec_tb.sv */
// Self-checking bench for the instruction subset executer.
// Assumes the design carries its own timing assertions; bench drives all ports.
`timescale 1ns/100ps
module core_subset_exec_tb;
  import core_subset_pkg::*;
  typedef struct {
    int          sel;
    logic [28:0] exp;
  } note_type;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [INSTR_W-1:0]   instr = '0;
  logic                 instrValid = 1'b0;
  logic [DATA_W-1:0]    fileRdData = '0;
  logic                 stackPush = 1'b0;
  logic [PC_W-1:0]      pushAddr = '0;
  logic                 wakePin = 1'b0;
  logic [PC_W:0]        cfgAddr = '0;
  logic [INSTR_W-1:0]   cfgProgrammed = '0;
  logic [PC_W-1:0]      pc;
  logic [DATA_W-1:0]    acc;
  status_type           status;
  file_write_type       fileWrite;
  logic                 globalIrqEnable;
  logic                 watchdogClear;
  logic                 oscHalt;
  logic [INSTR_W-1:0]   cfgData;
  note_type             notes[$];
  note_type             n;
  logic [28:0]          seen;
  string                nm[4] = '{"core", "pc", "cfg", "power"};
  int                   seed = 40672;
  int                   errorCnt = 0;
  int                   testsRun = 0;
  int                   op;
  logic [DATA_W-1:0]    eAcc;
  status_type           eSt;
  logic                 eGie;
  logic [15:0]          fw;
  logic [31:0]          r;
  logic [7:0]           v;
  logic [7:0]           res;
  logic [6:0]           f;
  logic                 d;
  logic [7:0]           lits[3] = '{8'hFF, 8'h00, 8'h5A};
  logic [INSTR_W-1:0]   rets[3] = '{OP_RETLIT | 14'h0096, OP_RETSUB, OP_RETIRQ};
  logic [PC_W-1:0]      addrs[3] = '{13'h1FFE, 13'h0A5C, 13'h0123};

  core_subset_exec i_core_subset_exec (.clk(clk), .rst(rst), .instr(instr),
    .instrValid(instrValid), .fileRdData(fileRdData), .stackPush(stackPush),
    .pushAddr(pushAddr), .wakePin(wakePin), .cfgAddr(cfgAddr),
    .cfgProgrammed(cfgProgrammed), .pc(pc), .acc(acc), .status(status),
    .fileWrite(fileWrite), .globalIrqEnable(globalIrqEnable),
    .watchdogClear(watchdogClear), .oscHalt(oscHalt), .cfgData(cfgData));

  always #25 clk = ~clk;

  task automatic test_done;
    if (errorCnt == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input int sel, input logic [28:0] e);
    notes.push_back('{sel, e});
  endtask

  task automatic expCore(input logic [15:0] w);
    chk(0, {eAcc, eSt, w});
  endtask

  // Config readback is exercised on every issued word, random cells
  task automatic issue(input logic [INSTR_W-1:0] i, input logic [DATA_W-1:0] fv);
    logic [31:0]        c;
    logic [PC_W:0]      ca;
    logic [INSTR_W-1:0] cp;
    c = $random(seed);
    ca = c[31] ? CONFIG_ADDR : c[13:0];
    cp = c[29:16];
    instr <= i;
    stackPush <= 1'b0;
    fileRdData <= fv;
    instrValid <= 1'b1;
    cfgAddr <= ca;
    cfgProgrammed <= cp;
    @(posedge clk);
    chk(2, {15'h0000, (ca == CONFIG_ADDR) ? ~cp : ALL_ONES});
  endtask

  task automatic push(input logic [PC_W-1:0] a);
    stackPush <= 1'b1;
    pushAddr <= a;
    instrValid <= 1'b0;
    @(posedge clk);
  endtask

  always @(negedge clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        // Address and data carry no meaning while no write is strobed
        0: seen = {acc, status, fileWrite.en, fileWrite.en ? fileWrite[14:0] : 15'h0000};
        1: seen = {15'h0000, pc, globalIrqEnable};
        2: seen = {15'h0000, cfgData};
        default: seen = {22'h000000, oscHalt, watchdogClear, status};
      endcase
      testsRun++;
      if (seen !== n.exp) begin
        errorCnt++;
        $display("BAD %s expected %h seen %h", nm[n.sel], n.exp, seen);
      end
    end
  end

  initial begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    test_done;
  end

  initial begin
    eAcc = 8'h00;
    eSt = STATUS_RESET;
    eGie = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (lits[j]) begin
      issue(OP_LOAD | {6'h00, lits[j]}, 8'hFF);
      eAcc = lits[j];
      expCore(16'h0000);
    end
    // First pass subtracts acc from itself so the zero result is covered
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      f = r[6:0];
      d = r[7];
      v = (i == 0) ? eAcc : ((i % 6 == 0) ? 8'h00 : r[15:8]);
      op = (i + 4) % 5;
      fw = 16'h0000;
      case (op)
        0: issue(OP_COPY | {6'h00, d, f}, v);
        1: issue(OP_STORE | {7'h00, f}, v);
        2: issue(OP_ROTL | {6'h00, d, f}, v);
        3: issue(OP_ROTR | {6'h00, d, f}, v);
        default: issue(OP_SUBLIT | {6'h00, v}, r[23:16]);
      endcase
      case (op)
        1: res = eAcc;
        2: res = {v[6:0], eSt.carry};
        3: res = {eSt.carry, v[7:1]};
        default: res = v;
      endcase
      if (op == 0) eSt.zero = (v == 8'h00);
      if (op == 2) eSt.carry = v[7];
      if (op == 3) eSt.carry = v[0];
      if (op == 4) begin
        res = v - eAcc;
        eSt.carry = (eAcc <= v);
        eSt.digitCarry = (eAcc[3:0] <= v[3:0]);
        eSt.zero = (res == 8'h00);
        eAcc = res;
      end else if (op == 1 || d) begin
        fw = {1'b1, f, res};
      end else begin
        eAcc = res;
      end
      expCore(fw);
    end
    push(addrs[2]);
    push(addrs[1]);
    push(addrs[0]);
    for (int j = 0; j < 3; j++) begin
      issue(rets[j], 8'h00);
      if (j == 0) eAcc = 8'h96;
      if (j == 2) eGie = 1'b1;
      expCore(16'h0000);
      chk(1, {15'h0000, addrs[j], eGie});
      issue(OP_LOAD | 14'h00C3, 8'h00);
      expCore(16'h0000);
    end
    issue(OP_SLEEP, 8'h00);
    eSt.powerDown = 1'b0;
    eSt.timeOut = 1'b1;
    chk(3, {22'h000000, 1'b1, 1'b1, eSt});
    issue(OP_LOAD | 14'h0077, 8'h00);
    chk(3, {22'h000000, 1'b1, 1'b0, eSt});
    expCore(16'h0000);
    wakePin <= 1'b1;
    instrValid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(3, {22'h000000, 1'b0, 1'b0, eSt});
    wakePin <= 1'b0;
    issue(OP_LOAD | 14'h003C, 8'h00);
    eAcc = 8'h3C;
    expCore(16'h0000);
    // Reset in mid-run must also drop the interrupt enable
    rst <= 1'b1;
    instrValid <= 1'b0;
    @(posedge clk);
    eAcc = 8'h00;
    eSt = STATUS_RESET;
    expCore(16'h0000);
    chk(1, {15'h0000, PC_RESET, 1'b0});
    rst <= 1'b0;
    @(posedge clk);
    issue(OP_LOAD | 14'h005A, 8'h00);
    eAcc = 8'h5A;
    expCore(16'h0000);
    @(posedge clk);
    test_done;
  end
endmodule
